/* dib_axi_host.sv */
// Purpose: AXI4-Lite host model for the boot controller
// Assumes: One write and one read under way at a time
// Notes: Released addresses and write data turn inverted so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module dib_axi_host (
  // Clock
  input wire logic clk_sys,
  // Write side
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read side
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Settings and restart commands reach the device only through this path; reconfig also comes from pins
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // dib_axi_host
`default_nettype wire

/* dib_boot_ctrl.sv */
// Purpose: Dual image boot controller with AXI4-Lite registers
// Assumes: One clock clk_sys, asynchronous active-high reset
// Notes: Image loading is modelled by a fixed load time per attempt
`timescale 1ns/100ps
`default_nettype none

module dib_boot_ctrl
  import dib_pkg::*;
#(
  parameter logic [31:0] LOAD_TIME_CYCLES = 32'(dib_pkg::LOAD_CYCLES),
  parameter logic [31:0] WDOG_TIME_CYCLES = 32'(dib_pkg::WDOG_CYCLES)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration pins, asynchronous
  input wire logic imageSelectPin,
  input wire logic configStatusPinN,
  input wire logic configRequestPinN,
  input wire logic crcErrorPin,
  // Configuration outputs
  output logic userReconfigRequestN,
  output logic userWatchdogRestartN,
  output logic configRamLoad,
  output logic bootImage,
  output logic userMode,
  // Interrupt
  output logic irq
);

  import dib_pkg::*;

  function automatic dib_sel_t decodeSel(input logic [7:0] addr);
    case (addr)
      OFS_CTRL: decodeSel = SEL_CTRL;
      OFS_UPGRADE_IN: decodeSel = SEL_UPGRADE;
      OFS_STATUS: decodeSel = SEL_STATUS;
      OFS_IRQ_STAT: decodeSel = SEL_IRQ_STAT;
      OFS_IRQ_MASK: decodeSel = SEL_IRQ_MASK;
      default: decodeSel = SEL_NONE;
    endcase
  endfunction

  // Synchronised pins
  logic [3:0] pinSync;
  dib_pin_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h6)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({crcErrorPin, configRequestPinN, configStatusPinN, imageSelectPin}),
    .syncOut(pinSync)
  );
  wire pinImage = pinSync[0];
  wire statusLow = !pinSync[1];
  wire requestLow = !pinSync[2];
  wire crcError = pinSync[3];

  // Register state
  logic [4:0] upgrade_q;
  logic [2:0] irqStat_q;
  logic [2:0] irqStat_d;
  logic [2:0] irqMask_q;
  logic causeCrc_q;
  logic causeWdog_q;
  logic failedImage_q;
  logic reverted_q;
  logic image_q;
  logic [31:0] loadCnt_q;
  logic [3:0] settle_q;
  dib_state_t state_q;
  dib_state_t state_d;

  // Bus state
  logic [7:0] awAddr_q;
  logic awHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;

  // Write commit and register decode
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire dib_sel_t wrSel = decodeSel(awAddr_q);
  wire dib_sel_t rdSel = decodeSel(s_axi_araddr);
  wire wrLow = doWrite && wStrb_q[0];
  wire hostReconfig = wrLow && (wrSel == SEL_CTRL) && wData_q[CTRL_RECONFIG];
  wire wdEnable = upgrade_q[UPG_WD_ENABLE];
  wire hostRestart = wrLow && (wrSel == SEL_CTRL) && wData_q[CTRL_WD_RESTART] && wdEnable;

  // State decode
  wire inPowerup = (state_q == ST_POWERUP);
  wire inLoad = (state_q == ST_LOAD);
  wire inUser = (state_q == ST_USER);
  wire inError = (state_q == ST_ERROR);
  wire inWait = (state_q == ST_WAIT);
  wire settled = (settle_q == SETTLE_CYCLES);
  wire loadDone = inLoad && (loadCnt_q == LOAD_TIME_CYCLES - 32'h1);

  // Watchdog runs only in user mode
  logic wdTimeout;
  dib_watchdog #(
    .TIMEOUT_CYCLES(WDOG_TIME_CYCLES)
  ) u_watchdog (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(wdEnable && inUser),
    .restart(hostRestart || loadDone),
    .timeout(wdTimeout)
  );

  // Reconfiguration sources and image choice
  wire trigger = statusLow || requestLow || hostReconfig;
  wire dualMode = upgrade_q[UPG_DUAL_MODE];
  wire pinChoice = dualMode && pinImage;
  wire nextImage = upgrade_q[UPG_OVR_VALID] ? upgrade_q[UPG_IMAGE] : pinChoice;
  wire loadCrcErr = inLoad && crcError;
  wire userErr = inUser && (crcError || wdTimeout);
  wire errEvent = loadCrcErr || userErr;
  wire secondErr = inError && reverted_q;
  wire revertNow = inError && !reverted_q;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POWERUP: begin
        if (settled) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (loadCrcErr) begin
          state_d = ST_ERROR;
        end else if (loadDone) begin
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        if (userErr) begin
          state_d = ST_ERROR;
        end else if (trigger) begin
          state_d = ST_LOAD;
        end
      end
      ST_ERROR: begin
        if (!reverted_q || upgrade_q[UPG_AUTO_RECONFIG]) begin
          state_d = ST_LOAD;
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trigger) begin
          state_d = ST_LOAD;
        end
      end
      default: state_d = ST_POWERUP;
    endcase
  end

  wire startLoad = (state_d == ST_LOAD) && !inLoad;

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_POWERUP;
      settle_q <= 4'h0;
      loadCnt_q <= 32'h0;
      image_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (inPowerup && !settled) begin
        settle_q <= settle_q + 4'h1;
      end
      loadCnt_q <= inLoad ? loadCnt_q + 32'h1 : 32'h0;
      // A failed image is never chosen again by a revert
      if (inPowerup && settled) begin
        image_q <= pinChoice;
      end else if (revertNow) begin
        image_q <= !image_q;
      end else if (startLoad) begin
        // Second error with auto reconfig picks by override or pin, not a revert
        image_q <= nextImage;
      end
    end
  end

  // Error record, readable once back in user mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      causeCrc_q <= 1'b0;
      causeWdog_q <= 1'b0;
      failedImage_q <= 1'b0;
      reverted_q <= 1'b0;
    end else begin
      if (errEvent) begin
        causeCrc_q <= crcError;
        causeWdog_q <= userErr && wdTimeout && !crcError;
        failedImage_q <= image_q;
      end
      if (revertNow) begin
        reverted_q <= 1'b1;
      end else if (trigger && (inUser || inWait)) begin
        reverted_q <= 1'b0;
      end
    end
  end

  // Configuration outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      userReconfigRequestN <= 1'b1;
      userWatchdogRestartN <= 1'b1;
      configRamLoad <= 1'b0;
      bootImage <= 1'b0;
      userMode <= 1'b0;
    end else begin
      userReconfigRequestN <= !hostReconfig;
      userWatchdogRestartN <= !hostRestart;
      // Follows the next state so load and user mode never overlap
      configRamLoad <= (state_d == ST_LOAD);
      bootImage <= (state_d == ST_LOAD) ? (revertNow ? !image_q :
        (inPowerup ? pinChoice : nextImage)) : image_q;
      userMode <= (state_d == ST_USER);
    end
  end

  // Interrupt status: set wins over read clear
  wire [2:0] irqEvents = {loadDone, secondErr, revertNow};
  wire irqRead = arTake && (rdSel == SEL_IRQ_STAT);
  assign irqStat_d = (irqRead ? 3'h0 : irqStat_q) | irqEvents;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqStat_q <= IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irqStat_q <= irqStat_d;
      irq <= |(irqStat_d & irqMask_q);
    end
  end

  // Host-written registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upgrade_q <= UPG_RESET;
      irqMask_q <= IRQ_RESET;
    end else if (wrLow) begin
      if (wrSel == SEL_UPGRADE) begin
        upgrade_q <= wData_q[4:0];
      end
      if (wrSel == SEL_IRQ_MASK) begin
        irqMask_q <= wData_q[2:0];
      end
    end
  end

  // Status word seen by the host
  wire [31:0] statusWord = {25'h0, inWait, reverted_q, failedImage_q, causeWdog_q,
    causeCrc_q, inUser, image_q};
  wire [31:0] readWord =
    (rdSel == SEL_UPGRADE) ? {27'h0, upgrade_q} :
    (rdSel == SEL_STATUS) ? statusWord :
    (rdSel == SEL_IRQ_STAT) ? {29'h0, irqStat_q} :
    (rdSel == SEL_IRQ_MASK) ? {29'h0, irqMask_q} : 32'h0;

  // AXI4-Lite write channels, address and data in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == SEL_NONE || wrSel == SEL_STATUS || wrSel == SEL_IRQ_STAT) ?
          RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dib_boot_ctrl

`default_nettype wire

/* dib_boot_ctrl_assertions.sv */
// Purpose: Port-level assertions for the boot controller
// Assumes: One clock domain, bound to dib_boot_ctrl
// Notes: Load length is bounded by a counter, not a long repetition
`timescale 1ns/100ps
`default_nettype none
module dib_boot_ctrl_checker #(
  parameter logic [31:0] LOAD_TIME_CYCLES = 32'd20,
  parameter logic [31:0] WDOG_TIME_CYCLES = 32'd50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Boot outputs
  input wire logic userReconfigRequestN,
  input wire logic userWatchdogRestartN,
  input wire logic configRamLoad,
  input wire logic userMode
);
  logic [31:0] loadRun_q;
  wire [31:0] loadRun_d = configRamLoad ? loadRun_q + 32'd1 : 32'd0;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loadRun_q <= '0;
    end else begin
      loadRun_q <= loadRun_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response missing");
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write channels not reopened");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data missing");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  property p_rcfg_pulse;
    !userReconfigRequestN |=> userReconfigRequestN;
  endproperty
  a_rcfg_pulse: assert property (p_rcfg_pulse) else $error("reconfig request too long");
  property p_wd_pulse;
    !userWatchdogRestartN |=> userWatchdogRestartN;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("restart pulse too long");
  property p_trigger;
    $fell(userReconfigRequestN) && $past(userMode) |-> ##[0:8] configRamLoad;
  endproperty
  a_trigger: assert property (p_trigger) else $error("request did not reload");
  property p_load_len;
    loadRun_q <= LOAD_TIME_CYCLES + 32'd1;
  endproperty
  a_load_len: assert property (p_load_len) else $error("image load too long");
  property p_load_user;
    configRamLoad |-> !userMode;
  endproperty
  a_load_user: assert property (p_load_user) else $error("user mode during load");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_reload: cover property ($fell(userReconfigRequestN) ##[1:8] configRamLoad);
endmodule // dib_boot_ctrl_checker
bind dib_boot_ctrl dib_boot_ctrl_checker #(
  .LOAD_TIME_CYCLES(LOAD_TIME_CYCLES), .WDOG_TIME_CYCLES(WDOG_TIME_CYCLES)
) u_chk (
  .clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .userReconfigRequestN(userReconfigRequestN), .userWatchdogRestartN(userWatchdogRestartN),
  .configRamLoad(configRamLoad), .userMode(userMode)
);
`default_nettype wire

/* dib_pin_sync.sv */
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk_sys
// Notes: Output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module dib_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          s1_q <= RESET_VAL[i];
          s2_q <= RESET_VAL[i];
          s3_q <= RESET_VAL[i];
          syncOut[i] <= RESET_VAL[i];
        end else begin
          s1_q <= pinIn[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Filters a one-cycle glitch at the cost of one more cycle
          if (s2_q == s3_q) begin
            syncOut[i] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule // dib_pin_sync

`default_nettype wire

/* dib_pkg.sv */
// Purpose: Shared constants for the dual image boot controller
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of aligned 32-bit words
`default_nettype none

package dib_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int LOAD_TIME_US = 100;
  localparam int LOAD_CYCLES = LOAD_TIME_US * CLK_MHZ;
  localparam int WDOG_TIME_US = 10000;
  localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
  localparam logic [3:0] SETTLE_CYCLES = 4'h4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UPGRADE_IN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control register bits (write one to act)
  localparam int CTRL_RECONFIG = 0;
  localparam int CTRL_WD_RESTART = 1;

  // Upgrade input register bits
  localparam int UPG_IMAGE = 0;
  localparam int UPG_OVR_VALID = 1;
  localparam int UPG_WD_ENABLE = 2;
  localparam int UPG_AUTO_RECONFIG = 3;
  localparam int UPG_DUAL_MODE = 4;
  localparam logic [4:0] UPG_RESET = 5'h10;

  // Status register bits
  localparam int STS_IMAGE = 0;
  localparam int STS_USER_MODE = 1;
  localparam int STS_CAUSE_CRC = 2;
  localparam int STS_CAUSE_WDOG = 3;
  localparam int STS_FAILED_IMAGE = 4;
  localparam int STS_REVERTED = 5;
  localparam int STS_WAITING = 6;

  // Interrupt status bits
  localparam int IRQ_REVERT = 0;
  localparam int IRQ_SECOND_ERR = 1;
  localparam int IRQ_LOAD_DONE = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum logic [2:0] {
    SEL_CTRL = 3'h0,
    SEL_UPGRADE = 3'h1,
    SEL_STATUS = 3'h2,
    SEL_IRQ_STAT = 3'h3,
    SEL_IRQ_MASK = 3'h4,
    SEL_NONE = 3'h7
  } dib_sel_t;

  // Boot sequencer states
  typedef enum logic [4:0] {
    ST_POWERUP = 5'b00001,
    ST_LOAD = 5'b00010,
    ST_USER = 5'b00100,
    ST_ERROR = 5'b01000,
    ST_WAIT = 5'b10000
  } dib_state_t;

endpackage

`default_nettype wire

/* dib_watchdog.sv */
// Purpose: User watchdog timer
// Assumes: Restart is a one-cycle pulse on clk_sys
// Notes: Timeout is a one-cycle pulse; count restarts afterwards
`timescale 1ns/100ps
`default_nettype none

module dib_watchdog #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'h0001_0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Event
  output logic timeout
);

  logic [31:0] count_q;
  wire atLimit = (count_q == TIMEOUT_CYCLES - 32'h1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_q <= 32'h0;
      timeout <= 1'b0;
    end else begin
      timeout <= enable && !restart && atLimit;
      if (!enable || restart || atLimit) begin
        count_q <= 32'h0;
      end else begin
        count_q <= count_q + 32'h1;
      end
    end
  end

endmodule // dib_watchdog

`default_nettype wire

/* test_dual_image_boot_control.sv */
// Purpose: Self-checking bench for the dual image boot controller
// Assumes: Short load and watchdog counts keep the run brief
// Notes: Expected values come from the bench register and boot model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_dual_image_boot_control;
  import dib_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic imageSelectPin = 1'b1;
  logic configStatusPinN = 1'b1;
  logic configRequestPinN = 1'b1;
  logic crcErrorPin = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, val, rng;
  logic [31:0] maskM = 32'h0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic userReconfigRequestN, userWatchdogRestartN, configRamLoad, bootImage, userMode, irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int nRestart = 0;
  int base;
  int bootQ[$];
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (userWatchdogRestartN === 1'b0) nRestart++;
  end
  dib_boot_ctrl #(.LOAD_TIME_CYCLES(32'd20), .WDOG_TIME_CYCLES(32'd50)) DUT (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .imageSelectPin(imageSelectPin),
    .configStatusPinN(configStatusPinN), .configRequestPinN(configRequestPinN), .crcErrorPin(crcErrorPin),
    .userReconfigRequestN(userReconfigRequestN), .userWatchdogRestartN(userWatchdogRestartN),
    .configRamLoad(configRamLoad), .bootImage(bootImage), .userMode(userMode), .irq(irq));
  dib_axi_host u_host (
    .clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er, input string nm);
    u_host.rd(a, val, resp);
    `CHK(nm, ex, val)
    `CHK(nm, er, resp)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.wr(a, d, 4'hf, resp);
  endtask
  // Bounded wait for load start (1) or user mode (0)
  task automatic wait_for(input bit load);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_sys);
      if ((load ? configRamLoad : userMode) === 1'b1) break;
    end
  endtask
  task automatic load_seq(input string nm);
    wait_for(1);
    wait_for(0);
    repeat (2) @(posedge clk_sys);
    `CHK(nm, 1'(bootQ.pop_front()), bootImage)
    `CHK(nm, 1'b1, userMode)
    $display("test %s done", nm);
  endtask
  // Pin event: 0 crc error, 1 status pin low, 2 request pin low
  task automatic pulse(input int k, input int n);
    @(posedge clk_sys);
    crcErrorPin <= (k == 0);
    configStatusPinN <= (k != 1);
    configRequestPinN <= (k != 2);
    repeat (n) @(posedge clk_sys);
    crcErrorPin <= 1'b0;
    configStatusPinN <= 1'b1;
    configRequestPinN <= 1'b1;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("mismatch run length expected done seen hang");
    finish_test();
  end
  initial begin
    rng = 32'd84;
    repeat (16) @(posedge clk_sys);
    `CHK("reset outputs", 7'h70, {awready, userReconfigRequestN, userWatchdogRestartN, configRamLoad, bootImage, userMode, irq})
    rst <= 1'b0;
    bootQ.push_back(1);
    load_seq("power-up image");
    rd_chk(OFS_STATUS, 32'h3, RESP_OKAY, "status after boot");
    rd_chk(OFS_UPGRADE_IN, 32'h10, RESP_OKAY, "upgrade reset");
    rd_chk(OFS_CTRL, 32'h0, RESP_OKAY, "control read");
    rd_chk(8'h14, 32'h0, RESP_SLVERR, "unmapped read");
    u_host.wr(OFS_STATUS, 32'hff, 4'hf, resp);
    `CHK("status write", RESP_SLVERR, resp)
    rd_chk(OFS_IRQ_STAT, 32'h4, RESP_OKAY, "load event");
    rd_chk(OFS_IRQ_STAT, 32'h0, RESP_OKAY, "cleared events");
    rd_chk(OFS_IRQ_MASK, 32'h0, RESP_OKAY, "mask reset");
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      // Random strobes: a write without lane 0 must leave the mask alone
      u_host.wr(OFS_IRQ_MASK, rng, rng[7:4], resp);
      if (rng[4]) maskM = rng & 32'h7;
      `CHK("strobe write", RESP_OKAY, resp)
      rd_chk(OFS_IRQ_MASK, maskM, RESP_OKAY, "mask readback");
    end
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_UPGRADE_IN, 32'h0);
    wr(OFS_CTRL, 32'h1);
    bootQ.push_back(0);
    load_seq("pin ignored");
    `CHK("irq raised", 1'b1, irq)
    rd_chk(OFS_IRQ_STAT, 32'h4, RESP_OKAY, "load event");
    repeat (3) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    imageSelectPin <= rng[0];
    wr(OFS_UPGRADE_IN, 32'h13);
    wr(OFS_CTRL, 32'h1);
    bootQ.push_back(1);
    load_seq("override beats pin");
    rd_chk(OFS_IRQ_STAT, 32'h4, RESP_OKAY, "load event");
    pulse(0, 2);
    bootQ.push_back(0);
    load_seq("crc revert");
    rd_chk(OFS_STATUS, 32'h36, RESP_OKAY, "revert cause");
    rd_chk(OFS_IRQ_STAT, 32'h5, RESP_OKAY, "revert event");
    wr(OFS_UPGRADE_IN, 32'h17);
    base = nRestart;
    repeat (4) begin
      wr(OFS_CTRL, 32'h2);
      repeat (25) @(posedge clk_sys);
    end
    `CHK("restart pulses", 4, nRestart - base)
    `CHK("kept alive", 1'b1, userMode)
    for (int i = 0; i < 100 && userMode !== 1'b0; i++) @(posedge clk_sys);
    repeat (60) @(posedge clk_sys);
    `CHK("no reload", 1'b0, configRamLoad)
    u_host.rd(OFS_STATUS, val, resp);
    `CHK("waiting state", 32'h48, val & 32'h4a)
    u_host.rd(OFS_IRQ_STAT, val, resp);
    `CHK("second error", 32'h2, val & 32'h2)
    wr(OFS_UPGRADE_IN, 32'h1b);
    for (int k = 1; k < 3; k++) begin
      bootQ.push_back(1);
      pulse(k, 6);
      load_seq("pin trigger");
    end
    rd_chk(OFS_IRQ_STAT, 32'h4, RESP_OKAY, "load events");
    wr(OFS_IRQ_MASK, 32'h0);
    pulse(0, 2);
    bootQ.push_back(0);
    load_seq("revert again");
    `CHK("masked irq", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h7);
    repeat (3) @(posedge clk_sys);
    `CHK("unmasked irq", 1'b1, irq)
    rd_chk(OFS_IRQ_STAT, 32'h5, RESP_OKAY, "revert event");
    pulse(0, 2);
    bootQ.push_back(1);
    load_seq("auto reconfig");
    u_host.rd(OFS_STATUS, val, resp);
    `CHK("not waiting", 32'h2, val & 32'h42)
    finish_test();
  end
endmodule // test_dual_image_boot_control
`default_nettype wire
